//--- hw/psr_reg_word.sv
`timescale 1ns/1ns
`default_nettype none

// one masked register word: writes land only on capable, writable bits
module psr_reg_word #(
	parameter logic [31:0] RW_MASK  = 32'h0000_0000,
	parameter logic [31:0] RST_VAL  = 32'h0000_0000
) (
	input  wire logic        i_clk,     // system clock
	input  wire logic        i_rst,     // async reset, active high
	input  wire logic        i_ce,      // clock enable
	input  wire logic        i_we,      // write strobe
	input  wire logic [31:0] i_wdata,   // write data
	input  wire logic [31:0] i_bmask,   // byte-lane bit mask
	input  wire logic [31:0] i_cap,     // capability mask
	output logic      [31:0] o_q        // stored value
);

	logic [31:0] en;

	always_comb
	begin
		en = RW_MASK & i_cap & i_bmask;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_q <= RST_VAL;
		else if (i_ce && i_we)
			o_q <= (o_q & ~en) | (i_wdata & en);
	end

endmodule

`default_nettype wire

//--- hw/psr_top.sv
`timescale 1ns/1ns
`default_nettype none

module psr_top (
	input  wire logic                    I_SYS_CLK,   // 25 MHz system clock
	input  wire logic                    I_RST,       // async reset, active high
	input  wire logic                    I_CE,        // clock enable, freezes all state low
	input  wire logic [31:0]             I_CAP_TWO,   // capability mask two
	input  wire logic [31:0]             I_CAP_FOUR,  // capability mask four
	input  wire psr_pkg::psr_axi_req_t   I_AXI_REQ,   // AXI4-Lite master to slave
	output psr_pkg::psr_axi_rsp_t        O_AXI_RSP,   // AXI4-Lite slave to master
	output psr_pkg::psr_resets_t         O_RESETS     // per-peripheral reset levels
);

	typedef struct packed
	{
		logic                               aw_got;
		logic [psr_pkg::ADDR_W-1:0]         aw_addr;
		logic                               w_got;
		logic [psr_pkg::DATA_W-1:0]         w_data;
		logic [3:0]                         w_strb;
		psr_pkg::psr_axi_rsp_t              rsp;
		psr_pkg::psr_resets_t               resets;
	} psr_state_t;

	psr_state_t   s_q;
	psr_state_t   s_d;
	logic [31:0]  periph_q;
	logic [31:0]  port_q;
	logic         we_periph;
	logic         we_port;
	logic [31:0]  bmask;

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			m[i*8 +: 8] = {8{strb[i]}};
		return m;
	endfunction

	function automatic logic [11:0] word_addr(input logic [11:0] a);
		return {a[11:2], 2'h0};
	endfunction

	// write commit happens when both address and data are held and no response pends
	logic do_write;
	assign do_write  = s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid;
	assign bmask     = strb_mask(s_q.w_strb);
	assign we_periph = do_write && (word_addr(s_q.aw_addr) == psr_pkg::PERIPH_RESET_CTRL_ONE_OFS);
	assign we_port   = do_write && (word_addr(s_q.aw_addr) == psr_pkg::PORT_RESET_CTRL_OFS);

	psr_reg_word #(
		.RW_MASK (psr_pkg::PERIPH_ONE_RW_MASK),
		.RST_VAL (psr_pkg::PERIPH_ONE_RESET)
	) u_periph (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_RST),
		.i_ce    (I_CE),
		.i_we    (we_periph),
		.i_wdata (s_q.w_data),
		.i_bmask (bmask),
		.i_cap   (I_CAP_TWO),
		.o_q     (periph_q)
	);

	psr_reg_word #(
		.RW_MASK (psr_pkg::PORT_RW_MASK),
		.RST_VAL (psr_pkg::PORT_RESET)
	) u_port (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_RST),
		.i_ce    (I_CE),
		.i_we    (we_port),
		.i_wdata (s_q.w_data),
		.i_bmask (bmask),
		.i_cap   (I_CAP_FOUR),
		.o_q     (port_q)
	);

	function automatic logic [31:0] read_word(input logic [11:0] a, input logic [31:0] p1,
		input logic [31:0] p2, input logic [31:0] c2, input logic [31:0] c4);
		logic [11:0] w;
		w = word_addr(a);
		if (w == psr_pkg::PERIPH_RESET_CTRL_ONE_OFS)
			return p1 & psr_pkg::PERIPH_ONE_RW_MASK;
		else if (w == psr_pkg::PORT_RESET_CTRL_OFS)
			return p2 & psr_pkg::PORT_RW_MASK;
		else if (w == psr_pkg::CAPABILITY_MASK_TWO_OFS)
			return c2;
		else if (w == psr_pkg::CAPABILITY_MASK_FOUR_OFS)
			return c4;
		else
			return 32'h0000_0000;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		logic [11:0] w;
		w = word_addr(a);
		return (w == psr_pkg::PERIPH_RESET_CTRL_ONE_OFS) || (w == psr_pkg::PORT_RESET_CTRL_OFS)
			|| (w == psr_pkg::CAPABILITY_MASK_TWO_OFS) || (w == psr_pkg::CAPABILITY_MASK_FOUR_OFS);
	endfunction

	function automatic logic writable(input logic [11:0] a);
		logic [11:0] w;
		w = word_addr(a);
		return (w == psr_pkg::PERIPH_RESET_CTRL_ONE_OFS) || (w == psr_pkg::PORT_RESET_CTRL_OFS);
	endfunction

	always_comb
	begin
		s_d = s_q;
		s_d.rsp.awready = 1'b0;
		s_d.rsp.wready  = 1'b0;
		s_d.rsp.arready = 1'b0;

		// write address channel
		if (!s_q.aw_got && !s_q.rsp.awready && I_AXI_REQ.awvalid)
			s_d.rsp.awready = 1'b1;
		if (s_q.rsp.awready && I_AXI_REQ.awvalid)
		begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = I_AXI_REQ.awaddr;
		end

		// write data channel
		if (!s_q.w_got && !s_q.rsp.wready && I_AXI_REQ.wvalid)
			s_d.rsp.wready = 1'b1;
		if (s_q.rsp.wready && I_AXI_REQ.wvalid)
		begin
			s_d.w_got  = 1'b1;
			s_d.w_data = I_AXI_REQ.wdata;
			s_d.w_strb = I_AXI_REQ.wstrb;
		end

		// commit and respond
		if (do_write)
		begin
			s_d.aw_got      = 1'b0;
			s_d.w_got       = 1'b0;
			s_d.rsp.bvalid  = 1'b1;
			s_d.rsp.bresp   = writable(s_q.aw_addr) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
		end
		if (s_q.rsp.bvalid && I_AXI_REQ.bready)
			s_d.rsp.bvalid = 1'b0;

		// read channel
		if (!s_q.rsp.arready && !s_q.rsp.rvalid && I_AXI_REQ.arvalid)
			s_d.rsp.arready = 1'b1;
		if (s_q.rsp.arready && I_AXI_REQ.arvalid)
		begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata  = read_word(I_AXI_REQ.araddr, periph_q, port_q, I_CAP_TWO, I_CAP_FOUR);
			s_d.rsp.rresp  = mapped(I_AXI_REQ.araddr) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
		end
		if (s_q.rsp.rvalid && I_AXI_REQ.rready)
			s_d.rsp.rvalid = 1'b0;

		// reset levels follow the stored controls
		s_d.resets.comparator_zero_reset      = periph_q[psr_pkg::COMPARATOR_ZERO_BIT];
		s_d.resets.gp_counter_reset           =
			periph_q[psr_pkg::GP_COUNTER_LSB +: psr_pkg::GP_COUNTER_CNT];
		s_d.resets.two_wire_serial_zero_reset = periph_q[psr_pkg::TWO_WIRE_ZERO_BIT];
		s_d.resets.sync_serial_reset          =
			periph_q[psr_pkg::SYNC_SERIAL_LSB +: psr_pkg::SYNC_SERIAL_CNT];
		s_d.resets.async_serial_reset         =
			periph_q[psr_pkg::ASYNC_SERIAL_LSB +: psr_pkg::ASYNC_SERIAL_CNT];
		s_d.resets.io_port_reset              =
			port_q[psr_pkg::IO_PORT_LSB +: psr_pkg::IO_PORT_CNT];
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
			s_q <= '0;
		else if (I_CE)
			s_q <= s_d;
	end

	assign O_AXI_RSP = s_q.rsp;
	assign O_RESETS  = s_q.resets;

endmodule

`default_nettype wire

//--- pkg/psr_pkg.sv
package psr_pkg;

	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned CAP_W    = 32;

	// register byte offsets
	localparam logic [11:0] PERIPH_RESET_CTRL_ONE_OFS = 12'h044;
	localparam logic [11:0] PORT_RESET_CTRL_OFS       = 12'h048;
	// capability mask readback, offsets of our own
	localparam logic [11:0] CAPABILITY_MASK_TWO_OFS   = 12'h04c;
	localparam logic [11:0] CAPABILITY_MASK_FOUR_OFS  = 12'h050;

	// writable bits and reset values of the peripheral and port reset registers
	localparam logic [31:0] PERIPH_ONE_RW_MASK = 32'h010f_1037;
	localparam logic [31:0] PORT_RW_MASK       = 32'h0000_00ff;
	localparam logic [31:0] PERIPH_ONE_RESET   = 32'h0000_0000;
	localparam logic [31:0] PORT_RESET         = 32'h0000_0000;

	// field positions
	localparam int unsigned COMPARATOR_ZERO_BIT  = 24;
	localparam int unsigned GP_COUNTER_LSB       = 16;
	localparam int unsigned GP_COUNTER_CNT       = 4;
	localparam int unsigned TWO_WIRE_ZERO_BIT    = 12;
	localparam int unsigned SYNC_SERIAL_LSB      = 4;
	localparam int unsigned SYNC_SERIAL_CNT      = 2;
	localparam int unsigned ASYNC_SERIAL_LSB     = 0;
	localparam int unsigned ASYNC_SERIAL_CNT     = 3;
	localparam int unsigned IO_PORT_LSB          = 0;
	localparam int unsigned IO_PORT_CNT          = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed
	{
		logic                  comparator_zero_reset;
		logic [3:0]            gp_counter_reset;
		logic                  two_wire_serial_zero_reset;
		logic [1:0]            sync_serial_reset;
		logic [2:0]            async_serial_reset;
		logic [7:0]            io_port_reset;
	} psr_resets_t;

	typedef struct packed
	{
		logic                  awvalid;
		logic [ADDR_W-1:0]     awaddr;
		logic                  wvalid;
		logic [DATA_W-1:0]     wdata;
		logic [3:0]            wstrb;
		logic                  bready;
		logic                  arvalid;
		logic [ADDR_W-1:0]     araddr;
		logic                  rready;
	} psr_axi_req_t;

	typedef struct packed
	{
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [DATA_W-1:0]     rdata;
		logic [1:0]            rresp;
	} psr_axi_rsp_t;

endpackage

//--- tb/psr_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module psr_top_monitor (
	input  wire logic                  I_SYS_CLK,  // clock
	input  wire logic                  I_RST,      // reset
	input  wire logic                  I_CE,       // enable
	input  wire logic [31:0]           I_CAP_TWO,  // mask two
	input  wire logic [31:0]           I_CAP_FOUR, // mask four
	input  wire psr_pkg::psr_axi_req_t I_AXI_REQ,  // bus request
	input  wire psr_pkg::psr_axi_rsp_t O_AXI_RSP,  // bus response
	input  wire psr_pkg::psr_resets_t  O_RESETS    // reset levels
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	a_comp_mask: assert property (!I_CAP_TWO[24] |-> $stable(O_RESETS.comparator_zero_reset))
		else $error("comparator bit moved while absent");
	a_ctr_mask: assert property ((($past(O_RESETS.gp_counter_reset) ^ O_RESETS.gp_counter_reset) & ~I_CAP_TWO[19:16]) == 4'h0)
		else $error("counter bit moved while absent");
	a_twire_mask: assert property (!I_CAP_TWO[12] |-> $stable(O_RESETS.two_wire_serial_zero_reset))
		else $error("two-wire bit moved while absent");
	a_sync_mask: assert property ((($past(O_RESETS.sync_serial_reset) ^ O_RESETS.sync_serial_reset) & ~I_CAP_TWO[5:4]) == 2'h0)
		else $error("sync serial bit moved while absent");
	a_async_mask: assert property ((($past(O_RESETS.async_serial_reset) ^ O_RESETS.async_serial_reset) & ~I_CAP_TWO[2:0]) == 3'h0)
		else $error("async serial bit moved while absent");
	a_port_mask: assert property ((($past(O_RESETS.io_port_reset) ^ O_RESETS.io_port_reset) & ~I_CAP_FOUR[7:0]) == 8'h0)
		else $error("port bit moved while absent");
	a_out_after_wr: assert property (!$stable(O_RESETS) |-> $past(O_AXI_RSP.bvalid) && !$past(O_AXI_RSP.bvalid, 2))
		else $error("reset outputs moved without a write");
	a_zero_rst: assert property ($fell(I_RST) |-> O_RESETS == '0)
		else $error("reset outputs not clear after reset");
	a_rd_lat: assert property (I_AXI_REQ.arvalid && O_AXI_RSP.arready |=> O_AXI_RSP.rvalid)
		else $error("read answer late");
	c_comp: cover property (O_RESETS.comparator_zero_reset);
	c_err: cover property (O_AXI_RSP.bvalid && O_AXI_RSP.bresp == psr_pkg::RESP_SLVERR);
	c_port: cover property (O_RESETS.io_port_reset == 8'hf0);
endmodule
bind psr_top psr_top_monitor i_mon (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_CAP_TWO(I_CAP_TWO),
	.I_CAP_FOUR(I_CAP_FOUR), .I_AXI_REQ(I_AXI_REQ), .O_AXI_RSP(O_AXI_RSP), .O_RESETS(O_RESETS));
`default_nettype wire

//--- tb/psr_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module psr_top_tb_top;
	localparam logic [31:0] P1 = psr_pkg::PERIPH_ONE_RW_MASK;
	localparam logic [31:0] P2 = psr_pkg::PORT_RW_MASK;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  ce = 1'b1;
	logic [31:0]           c2 = '1;
	logic [31:0]           c4 = '1;
	logic [31:0]           m1 = '0;
	logic [31:0]           m2 = '0;
	int                    n_errors = 0;
	int                    samples_checked = 0;
	int                    cyc = 0;
	psr_pkg::psr_axi_req_t rq = '0;
	psr_pkg::psr_axi_rsp_t rsp;
	psr_pkg::psr_resets_t  res;
	always #20 clk = ~clk;
	psr_top i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CAP_TWO(c2), .I_CAP_FOUR(c4),
		.I_AXI_REQ(rq), .O_AXI_RSP(rsp), .O_RESETS(res));
	task automatic end_sim();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= d;
		rq.wstrb <= 4'hf;
		rq.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.awready)
				rq.awvalid <= 1'b0;
			if (rsp.wready)
				rq.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		rq.bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.arready)
				rq.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		rq.rready <= 1'b0;
	endtask
	task automatic acc(input logic [11:0] a, input logic [31:0] d);
		logic [1:0]  r;
		logic [31:0] q;
		logic [1:0]  e;
		e = (a == 12'h044 || a == 12'h048) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
		wr(a, d, r);
		chk(32'(r), 32'(e));
		if (a == 12'h044)
			m1 = (m1 & ~(P1 & c2)) | (d & P1 & c2);
		if (a == 12'h048)
			m2 = (m2 & ~(P2 & c4)) | (d & P2 & c4);
		rd(a, q, r);
		chk(q, (a == 12'h044) ? m1 : (a == 12'h048) ? m2 : 32'h0);
		chk(32'(res), 32'({m1[24], m1[19:16], m1[12], m1[5:4], m1[2:0], m2[7:0]}));
	endtask
	task automatic t_zero();
		logic [31:0] q;
		logic [1:0]  r;
		rd(12'h044, q, r);
		chk(q, 32'h0);
		rd(12'h048, q, r);
		chk(q, 32'h0);
		chk(32'(res), 32'h0);
		$display("zero test done");
	endtask
	task automatic t_walk();
		for (int i = 0; i < 64; i++)
			acc((i < 32) ? 12'h044 : 12'h048, 32'h1 << (i % 32));
		$display("walk test done");
	endtask
	task automatic t_freeze();
		logic [31:0] q;
		logic [1:0]  r;
		@(posedge clk);
		ce <= 1'b0;
		rq.awvalid <= 1'b1;
		rq.awaddr <= 12'h048;
		rq.wvalid <= 1'b1;
		rq.wdata <= 32'h0000_00ff;
		rq.wstrb <= 4'hf;
		rq.bready <= 1'b1;
		repeat (6) @(posedge clk);
		chk(32'({rsp.awready, rsp.wready, rsp.bvalid}), 32'h0);
		chk(32'(res), 32'({m1[24], m1[19:16], m1[12], m1[5:4], m1[2:0], m2[7:0]}));
		ce <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.awready)
				rq.awvalid <= 1'b0;
			if (rsp.wready)
				rq.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		chk(32'(rsp.bresp), 32'(psr_pkg::RESP_OKAY));
		rq.bready <= 1'b0;
		m2 = (m2 & ~(P2 & c4)) | (32'h0000_00ff & P2 & c4);
		rd(12'h048, q, r);
		chk(q, m2);
		rd(12'h04c, q, r);
		chk(q, c2);
		rd(12'h050, q, r);
		chk(q, c4);
		$display("freeze test done");
	endtask
	task automatic t_mask();
		acc(12'h044, '1);
		acc(12'h048, '1);
		c2 <= 32'h00f0_1000;
		c4 <= 32'h0000_000f;
		acc(12'h044, 32'h0);
		acc(12'h048, 32'h0);
		c2 <= 32'h0;
		c4 <= 32'h0;
		acc(12'h044, '1);
		acc(12'h048, '1);
		acc(12'h054, '1);
		$display("mask test done");
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_zero();
		t_walk();
		t_freeze();
		t_mask();
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		m1 = '0;
		m2 = '0;
		t_zero();
		end_sim();
	end
endmodule
`default_nettype wire
